// *** dv/mtsa_asserts.sv ***
// Checker for the link between sequencer and host
`timescale 1ns/1ps
module mtsa_asserts #(
  parameter int unsigned BIT_CYCLES = 4
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [2:0] task_code,
  input wire logic task_wr,
  input wire logic [4:0] buf_count,
  input wire logic acquire_level_request,
  input wire logic acquire_clock_request,
  input wire logic [1:0] residual_level_mode,
  input wire logic [1:0] clock_loop_bandwidth,
  input wire logic irq_n,
  input wire logic buffer_empty_flag,
  input wire logic sync_found_in,
  input wire logic [2:0] level_mode_out,
  input wire logic [2:0] clock_bw_out
);
  localparam int B = BIT_CYCLES;
  localparam int EMPTY_MAX = 9 * BIT_CYCLES + 4;
  logic [2:0] code_q;
  logic [15:0] lev_q;
  logic [15:0] clk_q;
  logic srch_q;
  logic csr_q;
  logic sy_q;
  wire srch = task_wr && (task_code == 3'h5 || task_code == 3'h6);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  always_ff @(posedge clk_in) begin
    if (rst_in) code_q <= 3'h0;
    else if (task_wr) code_q <= task_code;
  end
  // Cycles since each request, parked at all ones when idle
  always_ff @(posedge clk_in) begin
    if (rst_in) lev_q <= 16'hffff;
    else if (acquire_level_request) lev_q <= 16'h0001;
    else if (lev_q != 16'hffff) lev_q <= lev_q + 16'h0001;
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) clk_q <= 16'hffff;
    else if (acquire_clock_request) clk_q <= 16'h0001;
    else if (clk_q != 16'hffff) clk_q <= clk_q + 16'h0001;
  end
  always_ff @(posedge clk_in) begin
    if (rst_in || acquire_level_request) srch_q <= 1'b0;
    else if (srch && lev_q < 28 * B) srch_q <= 1'b1;
  end
  always_ff @(posedge clk_in) begin
    if (rst_in || acquire_clock_request) csr_q <= 1'b0;
    else if (srch && clk_q < 14 * B) csr_q <= 1'b1;
  end
  always_ff @(posedge clk_in) begin
    if (rst_in || acquire_level_request) sy_q <= 1'b0;
    else if (sync_found_in) sy_q <= 1'b1;
  end
  sequence last_pop;
    code_q == 3'h3 && buf_count == 5'h00 && $past(buf_count) == 5'h01;
  endsequence
  sequence empty_seen;
    buffer_empty_flag && !irq_n;
  endsequence
  lev_clamp_a: assert property (lev_q > 1 && lev_q < B |-> level_mode_out == mtsa_pkg::LEV_CLAMP_CODE)
    else $error("clamp missing");
  lev_lossy_a: assert property (lev_q > B + 1 && (lev_q < 30 * B && !srch_q || srch_q && !sy_q)
    |-> level_mode_out == 3'h0) else $error("lossy missing");
  lev_resid_a: assert property (lev_q > 30 * B + 1 && lev_q != 16'hffff && !srch_q && $stable(residual_level_mode)
    |-> level_mode_out == {1'b0, residual_level_mode}) else $error("level residual wrong");
  bw_wide_a: assert property (clk_q > 1 && (clk_q < 16 * B && !csr_q || csr_q && !sy_q)
    |-> clock_bw_out == mtsa_pkg::MTSA_BW_WIDE) else $error("wide missing");
  bw_medium_a: assert property (!csr_q && clk_q > 16 * B + 1 && clk_q < 46 * B
    |-> clock_bw_out == mtsa_pkg::MTSA_BW_MEDIUM) else $error("medium missing");
  bw_resid_a: assert property (!csr_q && clk_q > 46 * B + 1 && clk_q != 16'hffff && $stable(clock_loop_bandwidth)
    |-> clock_bw_out == {1'b0, clock_loop_bandwidth}) else $error("bandwidth residual wrong");
  head_irq_a: assert property (code_q == 3'h1 && buf_count == 5'h00 && $past(buf_count) == 5'h01 |-> !irq_n)
    else $error("head interrupt missing");
  block_irq_a: assert property (code_q == 3'h2 && buf_count == 5'h00 && $past(buf_count) == 5'h01 |-> !irq_n)
    else $error("block interrupt missing");
  sync_irq_a: assert property (code_q == 3'h4 && buf_count == 5'h00 && $past(buf_count) == 5'h01 |-> !irq_n)
    else $error("sync interrupt missing");
  empty_irq_a: assert property (last_pop |-> ##[1:EMPTY_MAX] empty_seen)
    else $error("empty interrupt missing");
endmodule

// *** dv/test_modem_task_sequencing_and_acquisition.sv ***
// Bench joining the sequencer and host ends
`timescale 1ns/1ps
module test_modem_task_sequencing_and_acquisition;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic carrier = 1'b0;
  logic sync_f = 1'b0;
  logic rx_bit = 1'b0;
  logic [7:0] rdata, tx_b;
  logic tx_v, tx_en;
  logic [2:0] lev, bw;
  int miscompares = 0;
  int check_count = 0;
  mtsa_if link();
  always #2.5 clk_in = ~clk_in;
  always @(posedge clk_in) rx_bit <= ~rx_bit;
  mtsa_device #(.BIT_CYCLES(4)) mtsa_device_inst (.clk_in(clk_in), .rst_in(rst_in), .link(link),
    .sync_found_in(sync_f), .rx_bit_in(rx_bit), .rx_quality_in(8'h5a), .tx_byte_out(tx_b),
    .tx_byte_valid_out(tx_v), .level_mode_out(lev), .clock_bw_out(bw));
  mtsa_host #(.BIT_CYCLES(4)) mtsa_host_inst (.clk_in(clk_in), .rst_in(rst_in), .link(link), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .carrier_in(carrier), .rdata_out(rdata), .tx_enable_out(tx_en));
  mtsa_asserts #(.BIT_CYCLES(4)) mtsa_asserts_inst (.clk_in(clk_in), .rst_in(rst_in), .task_code(link.task_code),
    .task_wr(link.task_wr), .buf_count(link.buf_count), .acquire_level_request(link.acquire_level_request),
    .acquire_clock_request(link.acquire_clock_request), .residual_level_mode(link.residual_level_mode),
    .clock_loop_bandwidth(link.clock_loop_bandwidth), .irq_n(link.irq_n),
    .buffer_empty_flag(link.buffer_empty_flag), .sync_found_in(sync_f), .level_mode_out(lev), .clock_bw_out(bw));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic bits(input int n);
    repeat (n * 4) @(posedge clk_in);
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic tx(input logic [2:0] c, input int n, input logic [7:0] b);
    logic [7:0] q[$];
    int k;
    for (int i = 0; i < n; i++) wr_reg(mtsa_pkg::HREG_DATA, b + 8'(i));
    wr_reg(mtsa_pkg::HREG_CMD, {5'h00, c});
    for (k = 0; k < 3000 && q.size() < n; k++) begin
      @(posedge clk_in);
      if (tx_v === 1'b1) q.push_back(tx_b);
    end
    for (int i = 0; i < n; i++) chk(q[i], b + 8'(i));
    for (k = 0; k < 400 && link.irq_n !== 1'b0; k++) @(posedge clk_in);
    chk({7'h00, link.irq_n}, 8'h00);
    chk({7'h00, link.tx_not_rx}, 8'h01);
    $display("transmit task %0d done", c);
  endtask
  task automatic test_tx();
    int k;
    tx(mtsa_pkg::MTSA_TASK_TX_HEAD, 6, 8'h10);
    tx(mtsa_pkg::MTSA_TASK_TX_BLOCK, 18, 8'h40);
    tx(mtsa_pkg::MTSA_TASK_TX_SINGLE, 1, mtsa_pkg::PAD_BYTE);
    for (k = 0; k < 400 && link.buffer_empty_flag !== 1'b1; k++) @(posedge clk_in);
    chk({7'h00, link.buffer_empty_flag}, 8'h01);
  endtask
  // Early search holds the first stages until sync is seen
  task automatic acq(input logic [1:0] m, input logic [1:0] w, input bit early);
    int k;
    wr_reg(mtsa_pkg::HREG_CONFIG, {4'h0, w, m});
    wr_reg(mtsa_pkg::HREG_DATA, 8'hc3);
    wr_reg(mtsa_pkg::HREG_DATA, 8'h3c);
    wr_reg(mtsa_pkg::HREG_CMD, {5'h00, mtsa_pkg::MTSA_TASK_LOAD_SYNC});
    for (k = 0; k < 200 && link.acquire_level_request !== 1'b1; k++) @(posedge clk_in);
    chk({7'h00, link.tx_not_rx}, 8'h00);
    if (early) begin
      bits(5);
      wr_reg(mtsa_pkg::HREG_CMD, {5'h00, mtsa_pkg::MTSA_TASK_SEARCH_SYNC});
      wr_reg(mtsa_pkg::HREG_CMD, {5'h00, mtsa_pkg::MTSA_TASK_SEARCH_SYNC});
      bits(40);
      chk({5'h00, lev}, 8'h00);
      chk({5'h00, bw}, 8'(mtsa_pkg::MTSA_BW_WIDE));
      sync_f <= 1'b1;
      bits(2);
      chk({5'h00, lev}, {6'h00, m});
      chk({5'h00, bw}, 8'(mtsa_pkg::MTSA_BW_MEDIUM));
      bits(31);
      sync_f <= 1'b0;
    end else begin
      bits(18);
      chk({7'h00, link.irq_n}, 8'h00);
      chk({5'h00, lev}, 8'h00);
      chk({5'h00, bw}, 8'(mtsa_pkg::MTSA_BW_MEDIUM));
      bits(30);
    end
    chk({5'h00, lev}, {6'h00, m});
    chk({5'h00, bw}, {6'h00, w});
    $display("acquisition %0d done", m);
  endtask
  task automatic test_rx();
    int k;
    logic [7:0] v;
    carrier <= 1'b1;
    wr_reg(mtsa_pkg::HREG_CMD, {5'h00, mtsa_pkg::MTSA_TASK_RX_BLOCK});
    bits(1);
    for (k = 0; k < 3000 && link.rx_block_done !== 1'b1; k++) @(posedge clk_in);
    bits(1);
    chk({7'h00, link.irq_n}, 8'h00);
    rd_reg(mtsa_pkg::HREG_QUALITY, v);
    chk(v, 8'h5a);
    rd_reg(4'hf, v);
    chk(v, 8'h00);
    $display("receive block done");
  endtask
  initial begin
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    test_tx();
    for (int m = 0; m < 4; m++) acq(2'(m), 2'(3 - m), m == 3);
    test_rx();
    test_done();
  end
  initial begin
    #200000;
    miscompares++;
    test_done();
  end
endmodule

// *** rtl/mtsa_device.sv ***
// Modem end: task engine, data buffer and acquisition sequencer
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// [R1] Host sets direction bit before frames
// [R2] Host loads six bytes, waits, writes head
// [R3] Interrupt when sixth head byte read
// [R4] Host reads status, loads eighteen, writes block
// [R5] Interrupt when eighteenth block byte read
// [R6] Host loads pad byte, writes single task
// [R7] Messages end with ignored pad byte
// [R8] Pad byte pattern alternates bit pairs
// [R9] Buffer-empty interrupt after last byte sent
// [R10] Host loads sync, writes task, requests acquisition
// [R11] Interrupt when second sync byte read
// [R12] Host waits twelve bits, searches head
// [R13] Interrupt on frame head found
// [R14] Interrupt after block received and checked
// [R15] Idle automatically after last block
// [R16] Level: one bit clamp, then lossy
// [R17] Early search: lossy until sync found
// [R18] No search: residual after thirty bits
// [R19] Residual level mode from programmable field
// [R20] Early search: wide until sync found
// [R21] No search: wide sixteen bits
// [R22] Medium thirty bits then residual bandwidth
// [R23] Bit counter starts with request write
module mtsa_device #(
  parameter int unsigned BIT_CYCLES = mtsa_pkg::BIT_CYCLES,
  parameter int unsigned BUF_DEPTH = 32
) (
  input wire logic clk_in,
  input wire logic rst_in,
  mtsa_if.dev link,
  input wire logic sync_found_in,
  input wire logic rx_bit_in,
  input wire logic [7:0] rx_quality_in,
  output logic [7:0] tx_byte_out,
  output logic tx_byte_valid_out,
  output logic [2:0] level_mode_out,
  output logic [2:0] clock_bw_out
);
  initial begin
    if (BIT_CYCLES < 2 || BUF_DEPTH < mtsa_pkg::DATA_BLOCK_BYTES || BUF_DEPTH > 32) begin
      $error("mtsa_device: unsupported parameters");
    end
  end

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_TX = 5'b00010,
    ST_RX_SYNC = 5'b00100,
    ST_SEARCH = 5'b01000,
    ST_RX_BLOCK = 5'b10000
  } mtsa_state_t;

  function automatic logic [4:0] task_bytes(input logic [2:0] t);
    case (t)
      mtsa_pkg::MTSA_TASK_TX_HEAD: task_bytes = 5'(mtsa_pkg::FRAME_HEAD_BYTES);
      mtsa_pkg::MTSA_TASK_TX_BLOCK: task_bytes = 5'(mtsa_pkg::DATA_BLOCK_BYTES);
      mtsa_pkg::MTSA_TASK_TX_SINGLE: task_bytes = 5'(mtsa_pkg::SINGLE_BYTES);
      mtsa_pkg::MTSA_TASK_LOAD_SYNC: task_bytes = 5'(mtsa_pkg::SYNC_BYTES);
      mtsa_pkg::MTSA_TASK_RX_BLOCK: task_bytes = 5'(mtsa_pkg::DATA_BLOCK_BYTES);
      default: task_bytes = 5'(mtsa_pkg::HEADER_CTRL_BYTES);
    endcase
  endfunction

  mtsa_state_t state_q;
  logic [7:0] mem_q [BUF_DEPTH];
  logic [4:0] wr_ptr_q;
  logic [4:0] rd_ptr_q;
  logic [4:0] left_q;
  logic [15:0] bit_div_q;
  logic bit_tick;
  logic [7:0] shift_q;
  logic [2:0] bit_idx_q;
  logic [7:0] rx_shift_q;
  logic irq_q;
  logic empty_q;
  logic done_q;
  logic hdr_q;
  logic net_q;
  logic crc_q;
  logic [7:0] qual_q;
  logic [7:0] tx_byte_q;
  logic tx_valid_q;

  // Bit-rate timebase
  always_ff @(posedge clk_in) begin
    if (rst_in || link.acquire_level_request || link.acquire_clock_request ||
        bit_div_q == 16'(BIT_CYCLES - 1)) begin // R23
      bit_div_q <= 16'h0000;
    end else begin
      bit_div_q <= bit_div_q + 16'h0001;
    end
  end
  assign bit_tick = (bit_div_q == 16'(BIT_CYCLES - 1));

  // Host writes into buffer; device reads pop it
  always_ff @(posedge clk_in) begin
    if (link.buf_wr) begin
      mem_q[wr_ptr_q] <= link.buf_wdata;
    end
  end

  logic pop;
  logic push_rx;
  assign pop = (state_q == ST_TX || state_q == ST_RX_SYNC) && bit_tick && bit_idx_q == 3'h7 && left_q != 5'h00;

  always_ff @(posedge clk_in) begin
    if (rst_in || link.task_wr) begin
      wr_ptr_q <= 5'h00;
    end else if (link.buf_wr || push_rx) begin
      wr_ptr_q <= wr_ptr_q + 5'h01;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in || link.task_wr) begin
      rd_ptr_q <= 5'h00;
    end else if (pop || link.buf_rd) begin
      rd_ptr_q <= rd_ptr_q + 5'h01;
    end
  end

  // Task engine
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_q <= ST_IDLE;
      left_q <= 5'h00;
      bit_idx_q <= 3'h0;
    end else if (link.task_wr) begin
      left_q <= task_bytes(link.task_code);
      bit_idx_q <= 3'h0;
      case (link.task_code)
        mtsa_pkg::MTSA_TASK_TX_HEAD, mtsa_pkg::MTSA_TASK_TX_BLOCK, mtsa_pkg::MTSA_TASK_TX_SINGLE: state_q <= ST_TX;
        mtsa_pkg::MTSA_TASK_LOAD_SYNC: state_q <= ST_RX_SYNC;
        mtsa_pkg::MTSA_TASK_SEARCH_HEAD, mtsa_pkg::MTSA_TASK_SEARCH_SYNC: state_q <= ST_SEARCH;
        mtsa_pkg::MTSA_TASK_RX_BLOCK: state_q <= ST_RX_BLOCK;
        default: state_q <= ST_IDLE;
      endcase
    end else if (bit_tick) begin
      bit_idx_q <= bit_idx_q + 3'h1;
      case (state_q)
        ST_TX, ST_RX_SYNC: begin
          if (pop) begin
            left_q <= left_q - 5'h01;
          end
          if (left_q == 5'h00 && bit_idx_q == 3'h7) begin
            state_q <= ST_IDLE;
          end
        end
        ST_SEARCH: begin
          if (sync_found_in) begin
            state_q <= ST_RX_BLOCK;
            left_q <= 5'(mtsa_pkg::HEADER_CTRL_BYTES);
            bit_idx_q <= 3'h0;
          end
        end
        ST_RX_BLOCK: begin
          if (bit_idx_q == 3'h7) begin
            left_q <= left_q - 5'h01;
            if (left_q == 5'h01) begin
              state_q <= ST_IDLE; // R15
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Received bits shifted into buffer
  always_ff @(posedge clk_in) begin
    if (bit_tick) begin
      rx_shift_q <= {rx_shift_q[6:0], rx_bit_in};
    end
  end
  assign push_rx = state_q == ST_RX_BLOCK && bit_tick && bit_idx_q == 3'h7 && !link.task_wr;
  always_ff @(posedge clk_in) begin
    if (push_rx) begin
      mem_q[wr_ptr_q] <= {rx_shift_q[6:0], rx_bit_in};
    end
  end

  // Transmit serialiser
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      shift_q <= 8'h00;
      tx_byte_q <= 8'h00;
      tx_valid_q <= 1'b0;
    end else begin
      tx_valid_q <= pop && state_q == ST_TX;
      if (pop) begin
        shift_q <= mem_q[rd_ptr_q];
        tx_byte_q <= mem_q[rd_ptr_q];
      end
    end
  end

  // Interrupt and status flags
  logic last_pop;
  logic hdr_evt;
  logic blk_evt;
  logic empty_evt;
  assign last_pop = pop && left_q == 5'h01; // R3 R5 R11
  assign hdr_evt = state_q == ST_RX_BLOCK && push_rx && left_q == 5'h01 && hdr_q == 1'b0 && !done_q; // R13
  assign blk_evt = state_q == ST_RX_BLOCK && push_rx && left_q == 5'h01; // R14
  assign empty_evt = state_q == ST_TX && bit_tick && left_q == 5'h00 && bit_idx_q == 3'h7; // R9

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq_q <= 1'b0;
      empty_q <= 1'b0;
      done_q <= 1'b0;
      hdr_q <= 1'b0;
      net_q <= 1'b0;
      crc_q <= 1'b0;
      qual_q <= 8'h00;
    end else begin
      if (last_pop || blk_evt || empty_evt) begin
        irq_q <= 1'b1;
      end else if (link.task_wr) begin
        irq_q <= 1'b0;
      end
      if (empty_evt) begin
        empty_q <= 1'b1;
      end else if (link.task_wr) begin
        empty_q <= 1'b0;
      end
      if (blk_evt) begin
        done_q <= 1'b1;
        hdr_q <= hdr_evt;
        net_q <= rx_shift_q[0];
        crc_q <= ^rx_shift_q;
        qual_q <= rx_quality_in;
      end else if (link.task_wr) begin
        done_q <= 1'b0;
      end
    end
  end

  // Acquisition sequencer
  logic [5:0] lev_bits_q;
  logic [6:0] clk_bits_q;
  logic lev_run_q;
  logic clk_run_q;
  logic lev_search_q;
  logic clk_search_q;
  logic lev_locked_q;
  logic clk_med_q;
  logic [5:0] med_bits_q;
  logic search_wr;
  assign search_wr = link.task_wr && (link.task_code == mtsa_pkg::MTSA_TASK_SEARCH_HEAD ||
                     link.task_code == mtsa_pkg::MTSA_TASK_SEARCH_SYNC);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      lev_run_q <= 1'b0;
      lev_bits_q <= 6'h00;
      lev_search_q <= 1'b0;
      lev_locked_q <= 1'b0;
      level_mode_out <= 3'({mtsa_pkg::RESIDUAL_LEVEL_MODE_RESET_VAL});
    end else if (link.acquire_level_request) begin
      lev_run_q <= 1'b1; // R23
      lev_bits_q <= 6'h00;
      lev_search_q <= 1'b0;
      lev_locked_q <= 1'b0;
      level_mode_out <= mtsa_pkg::LEV_CLAMP_CODE; // R16
    end else if (lev_run_q) begin
      if (search_wr && lev_bits_q < 6'(mtsa_pkg::LEV_SFS_WINDOW_BITS)) begin
        lev_search_q <= 1'b1; // R17
      end
      if (bit_tick && lev_bits_q != 6'h3f) begin
        lev_bits_q <= lev_bits_q + 6'h01;
      end
      if (lev_bits_q >= 6'(mtsa_pkg::CLAMP_BITS)) begin
        level_mode_out <= {1'b0, mtsa_pkg::MTSA_LEV_LOSSY}; // R16
      end
      if ((lev_search_q && sync_found_in) || lev_locked_q) begin
        lev_locked_q <= 1'b1;
        level_mode_out <= {1'b0, link.residual_level_mode}; // R17 R19
      end else if (!lev_search_q && lev_bits_q >= 6'(mtsa_pkg::LEV_TIMEOUT_BITS)) begin
        level_mode_out <= {1'b0, link.residual_level_mode}; // R18 R19
      end
    end else begin
      level_mode_out <= {1'b0, link.residual_level_mode}; // R19
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      clk_run_q <= 1'b0;
      clk_bits_q <= 7'h00;
      clk_search_q <= 1'b0;
      clk_med_q <= 1'b0;
      med_bits_q <= 6'h00;
      clock_bw_out <= {1'b0, mtsa_pkg::CLKBW_RESET_VAL};
    end else if (link.acquire_clock_request) begin
      clk_run_q <= 1'b1; // R23
      clk_bits_q <= 7'h00;
      clk_search_q <= 1'b0;
      clk_med_q <= 1'b0;
      med_bits_q <= 6'h00;
      clock_bw_out <= mtsa_pkg::MTSA_BW_WIDE;
    end else if (clk_run_q) begin
      if (search_wr && clk_bits_q < 7'(mtsa_pkg::CLK_SFS_WINDOW_BITS)) begin
        clk_search_q <= 1'b1; // R20
      end
      if (bit_tick && clk_bits_q != 7'h7f) begin
        clk_bits_q <= clk_bits_q + 7'h01;
      end
      if (!clk_med_q) begin
        if ((clk_search_q && sync_found_in) ||
            (!clk_search_q && clk_bits_q >= 7'(mtsa_pkg::CLK_WIDE_BITS))) begin
          clk_med_q <= 1'b1; // R20 R21
          clock_bw_out <= mtsa_pkg::MTSA_BW_MEDIUM;
        end
      end else if (med_bits_q >= 6'(mtsa_pkg::CLK_MEDIUM_BITS)) begin
        clk_run_q <= 1'b0;
        clock_bw_out <= {1'b0, link.clock_loop_bandwidth}; // R22
      end else if (bit_tick) begin
        med_bits_q <= med_bits_q + 6'h01; // R22
      end
    end else begin
      clock_bw_out <= {1'b0, link.clock_loop_bandwidth};
    end
  end

  assign link.irq_n = !irq_q;
  assign link.buffer_empty_flag = empty_q;
  assign link.rx_block_done = done_q;
  assign link.header_check_flag = hdr_q;
  assign link.network_type_flag = net_q;
  assign link.crc_ok = crc_q;
  assign link.quality = qual_q;
  assign link.buf_rdata = mem_q[rd_ptr_q];
  assign link.buf_count = left_q;
  assign tx_byte_out = tx_byte_q;
  assign tx_byte_valid_out = tx_valid_q;
endmodule

// *** rtl/mtsa_host.sv ***
// Host end: frame send and receive sequences driven by software registers
`timescale 1ns/1ps
module mtsa_host #(
  parameter int unsigned BIT_CYCLES = mtsa_pkg::BIT_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_in,
  mtsa_if.host link,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic carrier_in,
  output logic [7:0] rdata_out,
  output logic tx_enable_out
);
  initial begin
    if (BIT_CYCLES < 2) begin
      $error("mtsa_host: unsupported parameters");
    end
  end

  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_WAIT = 4'b0010,
    H_TASK = 4'b0100,
    H_IRQ = 4'b1000
  } mtsa_hstate_t;

  mtsa_hstate_t st_q;
  logic [15:0] div_q;
  logic tick;
  logic [4:0] wait_q;
  logic [2:0] task_q;
  logic [7:0] cfg_q;
  logic [7:0] data_q;
  logic [7:0] rxd_q;
  logic busy_q;
  logic tx_q;
  logic wr_q;
  logic tw_q;
  logic rd_q;
  logic [7:0] bytes_q;
  logic acq_q;

  always_ff @(posedge clk_in) begin
    if (rst_in || tick) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end
  assign tick = (div_q == 16'(BIT_CYCLES - 1));

  // Software writes: data bytes are registered in data_q and reach the modem buffer a cycle later; commands start sequences
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cfg_q <= 8'h00;
      data_q <= 8'h00;
      wr_q <= 1'b0;
      tx_q <= 1'b0;
      task_q <= 3'h0;
      st_q <= H_IDLE;
      wait_q <= 5'h00;
      tw_q <= 1'b0;
      acq_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      wr_q <= wr_in && addr_in == mtsa_pkg::HREG_DATA;
      tw_q <= 1'b0;
      acq_q <= 1'b0;
      if (wr_in && addr_in == mtsa_pkg::HREG_DATA) begin
        data_q <= wdata_in;
      end
      if (wr_in && addr_in == mtsa_pkg::HREG_CONFIG) begin
        cfg_q <= wdata_in;
      end
      case (st_q)
        H_IDLE: begin
          if (wr_in && addr_in == mtsa_pkg::HREG_CMD) begin
            task_q <= wdata_in[2:0];
            tx_q <= wdata_in[2:0] inside {mtsa_pkg::MTSA_TASK_TX_HEAD, mtsa_pkg::MTSA_TASK_TX_BLOCK,
                                          mtsa_pkg::MTSA_TASK_TX_SINGLE}; // R1
            wait_q <= (wdata_in[2:0] == mtsa_pkg::MTSA_TASK_TX_HEAD ||
                       wdata_in[2:0] == mtsa_pkg::MTSA_TASK_LOAD_SYNC) ? 5'(mtsa_pkg::SETTLE_BITS) : // R2 R10
                      (wdata_in[2:0] == mtsa_pkg::MTSA_TASK_SEARCH_HEAD) ? 5'(mtsa_pkg::SFH_WAIT_BITS) : // R12
                      5'h00;
            busy_q <= 1'b1;
            st_q <= H_WAIT;
          end
        end
        H_WAIT: begin
          if (wait_q == 5'h00) begin
            st_q <= H_TASK;
          end else if (tick) begin
            wait_q <= wait_q - 5'h01;
          end
        end
        H_TASK: begin
          tw_q <= 1'b1; // R4 R6
          acq_q <= task_q == mtsa_pkg::MTSA_TASK_LOAD_SYNC; // R10
          st_q <= H_IRQ;
        end
        H_IRQ: begin
          if (!link.irq_n || (wr_in && addr_in == mtsa_pkg::HREG_CMD && wdata_in[mtsa_pkg::CMD_STOP])) begin
            busy_q <= 1'b0;
            st_q <= H_IDLE;
          end
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end

  // Register read port
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_out <= 8'h00;
      rd_q <= 1'b0;
      rxd_q <= 8'h00;
    end else begin
      rd_q <= rd_in && addr_in == mtsa_pkg::HREG_RXDATA;
      if (rd_q) begin
        rxd_q <= link.buf_rdata;
      end
      if (rd_in) begin
        case (addr_in)
          mtsa_pkg::HREG_CMD: rdata_out <= {5'h00, task_q};
          mtsa_pkg::HREG_STATUS: rdata_out <= {busy_q, ~link.irq_n, link.buffer_empty_flag, link.rx_block_done,
                                               link.header_check_flag, link.network_type_flag, link.crc_ok, tx_q};
          mtsa_pkg::HREG_RXDATA: rdata_out <= link.buf_rdata;
          mtsa_pkg::HREG_CONFIG: rdata_out <= cfg_q;
          mtsa_pkg::HREG_QUALITY: rdata_out <= link.quality;
          default: rdata_out <= 8'h00;
        endcase
      end
    end
  end

  // Transmitter held on until buffer-empty seen
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tx_enable_out <= 1'b0;
      bytes_q <= 8'h00;
    end else begin
      if (tw_q && tx_q) begin
        tx_enable_out <= 1'b1;
      end else if (link.buffer_empty_flag) begin
        tx_enable_out <= 1'b0; // R9
      end
      if (wr_q) begin
        bytes_q <= bytes_q + 8'h01;
      end
    end
  end

  assign link.tx_not_rx = tx_q;
  assign link.task_code = task_q;
  assign link.task_wr = tw_q;
  assign link.buf_wdata = data_q;
  assign link.buf_wr = wr_q;
  assign link.buf_rd = rd_q;
  assign link.acquire_level_request = acq_q;
  assign link.acquire_clock_request = acq_q;
  assign link.residual_level_mode = cfg_q[1:0];
  assign link.clock_loop_bandwidth = cfg_q[3:2];
endmodule

// *** shared/mtsa_if.sv ***
// Parallel link between modem sequencer and host controller
`timescale 1ns/1ps
interface mtsa_if;
  logic tx_not_rx;
  logic [2:0] task_code;
  logic task_wr;
  logic [7:0] buf_wdata;
  logic buf_wr;
  logic [7:0] buf_rdata;
  logic buf_rd;
  logic acquire_level_request;
  logic acquire_clock_request;
  logic [1:0] residual_level_mode;
  logic [1:0] clock_loop_bandwidth;
  logic irq_n;
  logic buffer_empty_flag;
  logic rx_block_done;
  logic header_check_flag;
  logic network_type_flag;
  logic crc_ok;
  logic [7:0] quality;
  logic [4:0] buf_count;
  modport dev (
    input tx_not_rx, task_code, task_wr, buf_wdata, buf_wr, buf_rd,
    input acquire_level_request, acquire_clock_request, residual_level_mode, clock_loop_bandwidth,
    output buf_rdata, irq_n, buffer_empty_flag, rx_block_done, header_check_flag,
    output network_type_flag, crc_ok, quality, buf_count
  );
  modport host (
    output tx_not_rx, task_code, task_wr, buf_wdata, buf_wr, buf_rd,
    output acquire_level_request, acquire_clock_request, residual_level_mode, clock_loop_bandwidth,
    input buf_rdata, irq_n, buffer_empty_flag, rx_block_done, header_check_flag,
    input network_type_flag, crc_ok, quality, buf_count
  );
endinterface

// *** shared/mtsa_pkg.sv ***
// Shared constants and types for the modem task sequencer and its host
package mtsa_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned BIT_RATE_HZ = 8_000;
  localparam int unsigned BIT_CYCLES = CLK_HZ / BIT_RATE_HZ;
  localparam int unsigned FRAME_HEAD_BYTES = 6;
  localparam int unsigned DATA_BLOCK_BYTES = 18;
  localparam int unsigned SINGLE_BYTES = 1;
  localparam int unsigned SYNC_BYTES = 2;
  localparam int unsigned HEADER_CTRL_BYTES = 2;
  localparam int unsigned SETTLE_BITS = 2;
  localparam int unsigned SFH_WAIT_BITS = 12;
  localparam int unsigned CLAMP_BITS = 1;
  localparam int unsigned LEV_SFS_WINDOW_BITS = 28;
  localparam int unsigned LEV_TIMEOUT_BITS = 30;
  localparam int unsigned CLK_SFS_WINDOW_BITS = 14;
  localparam int unsigned CLK_WIDE_BITS = 16;
  localparam int unsigned CLK_MEDIUM_BITS = 30;
  localparam logic [7:0] PAD_BYTE = 8'h33;
  localparam logic [7:0] TASK_RESET_VAL = 8'h00;
  localparam logic [1:0] RESIDUAL_LEVEL_MODE_RESET_VAL = 2'h0;
  localparam logic [1:0] CLKBW_RESET_VAL = 2'h0;
  // Task codes
  typedef enum logic [2:0] {
    MTSA_TASK_NONE = 3'h0,
    MTSA_TASK_TX_HEAD = 3'h1,
    MTSA_TASK_TX_BLOCK = 3'h2,
    MTSA_TASK_TX_SINGLE = 3'h3,
    MTSA_TASK_LOAD_SYNC = 3'h4,
    MTSA_TASK_SEARCH_HEAD = 3'h5,
    MTSA_TASK_SEARCH_SYNC = 3'h6,
    MTSA_TASK_RX_BLOCK = 3'h7
  } mtsa_task_t;
  // Level modes
  typedef enum logic [1:0] {
    MTSA_LEV_LOSSY = 2'h0,
    MTSA_LEV_PEAK = 2'h1,
    MTSA_LEV_AVG = 2'h2,
    MTSA_LEV_HOLD = 2'h3
  } mtsa_lev_t;
  localparam logic [2:0] LEV_CLAMP_CODE = 3'h4;
  // Clock loop bandwidths
  typedef enum logic [2:0] {
    MTSA_BW_WIDE = 3'h4,
    MTSA_BW_MEDIUM = 3'h5,
    MTSA_BW_RES0 = 3'h0,
    MTSA_BW_RES1 = 3'h1,
    MTSA_BW_RES2 = 3'h2,
    MTSA_BW_RES3 = 3'h3
  } mtsa_bw_t;
  // Host register map
  localparam logic [3:0] HREG_CMD = 4'h0;
  localparam logic [3:0] HREG_DATA = 4'h1;
  localparam logic [3:0] HREG_STATUS = 4'h2;
  localparam logic [3:0] HREG_RXDATA = 4'h3;
  localparam logic [3:0] HREG_CONFIG = 4'h4;
  localparam logic [3:0] HREG_QUALITY = 4'h5;
  localparam int unsigned CMD_SEND_FRAME = 0;
  localparam int unsigned CMD_RECEIVE = 1;
  localparam int unsigned CMD_STOP = 2;
endpackage
